//--- dcw_consts.vh
// Constants for the drive command word decoder: offsets, bits, resets.
// Assumes inclusion by bare name from the decoder design files.
`ifndef DCW_CONSTS_VH
`define DCW_CONSTS_VH

// APB byte offsets, 12-bit address space
`define DCW_AW 12
`define DCW_OFF_CMD 12'h000
`define DCW_OFF_CTRL 12'h004
`define DCW_OFF_STATUS 12'h008
`define DCW_OFF_ACC_CNT 12'h00C
`define DCW_OFF_IGN_CNT 12'h010
`define DCW_OFF_FLAGS 12'h014

// Command word bit positions
`define DCW_BIT_PRESET_LO 0
`define DCW_BIT_PRESET_HI 1
`define DCW_BIT_RSVD2 2
`define DCW_BIT_COAST_N 3
`define DCW_BIT_QSTOP_N 4
`define DCW_BIT_HOLD_N 5
`define DCW_BIT_START 6
`define DCW_BIT_ACK 7
`define DCW_BIT_JOG 8
`define DCW_BIT_RAMP 9
`define DCW_BIT_VALID 10
`define DCW_BIT_RSVD11 11
`define DCW_BIT_USER_LO 12
`define DCW_BIT_USER_HI 15

// Control register fields
`define DCW_CTRL_SRC 0
`define DCW_CTRL_MAP_LO 4
`define DCW_CTRL_MAP_HI 7

// Flags register fields (write one to clear)
`define DCW_FLAG_RSVD2 0
`define DCW_FLAG_RSVD11 1

// Reset values: an all-zero word means coast, quick stop and stop
`define DCW_CMD_RST 16'h0000
`define DCW_CTRL_RST 32'h000000F0
`define DCW_CNT_RST 16'h0000

`endif

//--- dcw_decoder.v
// Drive command word decoder with an APB register slave.
// Assumes process data and fault inputs are synchronous to clk;
// an APB master on the same clock reaches the registers.
//
// Operation
// - Every command but the bit 7 acknowledge follows the present bit levels; no sequencing state.
// - Bits 1:0 select preset reference one to four.
// - Bit 3 low coasts the motor at once; high does nothing.
// - Bit 4 low quick-stops on the quick-stop ramp; high does nothing.
// - Bit 5 low freezes output frequency; high does nothing.
// - Bit 6 high permits start; low stops on the ramp-down setting.
// - Bit 7 acknowledges faults only on a rising edge.
// - Acknowledge clears a fault only if cause gone and other ack given.
// - Bit 8 high drives output to jog speed; low does nothing.
// - Bit 9 high selects ramp two, low selects ramp one.
// - Bit 10 low ignores new data but that bit; other commands keep the last accepted word.
// - Bit 11 is reserved and feeds no command; it only sets a sticky flag.
// - Bits 15:12 pass to application control through a configured map.
`timescale 1ns/1ps
`include "dcw_consts.vh"
module dcw_decoder (
  // Clock and reset
  input wire clk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`DCW_AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Cyclic process data from the fieldbus
  input wire [15:0] pd_word,
  input wire pd_strobe,
  // Fault sources from the drive
  input wire fault_set,
  input wire fault_cond,
  input wire other_ack_ok,
  // Decoded commands
  output reg [1:0] preset_sel_r,
  output reg coast_r,
  output reg quick_stop_r,
  output reg freq_hold_r,
  output reg start_en_r,
  output reg ramp_stop_r,
  output reg jog_r,
  output reg ramp2_sel_r,
  output reg bus_control_r,
  output reg [3:0] user_bits_r,
  // Fault state
  output wire fault_r,
  output wire ack_refused_r
);

  // Register file and bus state
  reg [31:0] ctrl_r;
  reg [15:0] acc_word_r;
  reg [15:0] last_rx_r;
  reg [15:0] acc_cnt_r;
  reg [15:0] ign_cnt_r;
  reg [1:0] flags_r;
  reg [1:0] flags_nxt;

  // Arrival of a new word
  reg rx_take;
  reg [15:0] rx_word;

  wire setup_ph;
  wire access_ph;
  wire wr_go;
  wire ack_pulse;

  // True when the bus address hits a given register offset
  function hit;
    input [`DCW_AW-1:0] addr;
    input [`DCW_AW-1:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // Known register offsets; anything else answers with an error
  function mapped;
    input [`DCW_AW-1:0] addr;
    begin
      mapped = hit(addr, `DCW_OFF_CMD) |
               hit(addr, `DCW_OFF_CTRL) |
               hit(addr, `DCW_OFF_STATUS) |
               hit(addr, `DCW_OFF_ACC_CNT) |
               hit(addr, `DCW_OFF_IGN_CNT) |
               hit(addr, `DCW_OFF_FLAGS);
    end
  endfunction

  // Counter that stops at its top value instead of wrapping
  function [15:0] sat_inc;
    input [15:0] v;
    begin
      if (v == 16'hFFFF) begin
        sat_inc = v;
      end else begin
        sat_inc = v + 16'h0001;
      end
    end
  endfunction

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable & pready;
  assign wr_go = access_ph & pwrite & ~pslverr;

  // APB answer: ready in the first cycle of the access phase, never later.
  // Read data is captured at the end of setup, so it is steady
  // throughout the access phase.
  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup_ph;
      if (setup_ph) begin
        pslverr <= ~mapped(paddr);
        prdata <= 32'h00000000;
        if (!pwrite) begin
          case (paddr)
            `DCW_OFF_CTRL: begin
              prdata <= ctrl_r;
            end
            `DCW_OFF_STATUS: begin
              prdata <= {14'h0000, ack_refused_r, fault_r,
                         acc_word_r};
            end
            `DCW_OFF_ACC_CNT: begin
              prdata <= {16'h0000, acc_cnt_r};
            end
            `DCW_OFF_IGN_CNT: begin
              prdata <= {16'h0000, ign_cnt_r};
            end
            `DCW_OFF_FLAGS: begin
              prdata <= {30'h00000000, flags_r};
            end
            default: begin
              // Command word is write-only; it reads as zero
              prdata <= 32'h00000000;
            end
          endcase
        end
      end else if (access_ph) begin
        pslverr <= 1'b0;
      end
    end
  end

  // Control register: word source and user bit map
  always @(posedge clk) begin
    if (rst) begin
      ctrl_r <= `DCW_CTRL_RST;
    end else if (wr_go && hit(paddr, `DCW_OFF_CTRL)) begin
      ctrl_r <= {24'h000000,
                 pwdata[`DCW_CTRL_MAP_HI:`DCW_CTRL_MAP_LO],
                 3'h0, pwdata[`DCW_CTRL_SRC]};
    end
  end

  // Source select: the fieldbus strobe, or software writing the
  // command register. The unselected source is dropped, so the two
  // can never tear one word between them.
  always @* begin
    rx_take = 1'b0;
    rx_word = pd_word;
    if (ctrl_r[`DCW_CTRL_SRC]) begin
      rx_take = wr_go & hit(paddr, `DCW_OFF_CMD);
      rx_word = pwdata[15:0];
    end else begin
      rx_take = pd_strobe;
      rx_word = pd_word;
    end
  end

  // Word acceptance. The whole word lands in one edge; with the
  // valid bit low only that bit is taken, and the other commands
  // stay at the last word that arrived with valid high.
  always @(posedge clk) begin
    if (rst) begin
      acc_word_r <= `DCW_CMD_RST;
      last_rx_r <= `DCW_CMD_RST;
      acc_cnt_r <= `DCW_CNT_RST;
      ign_cnt_r <= `DCW_CNT_RST;
    end else if (rx_take) begin
      last_rx_r <= rx_word;
      if (rx_word[`DCW_BIT_VALID]) begin
        acc_word_r <= rx_word;
        acc_cnt_r <= sat_inc(acc_cnt_r);
      end else begin
        acc_word_r[`DCW_BIT_VALID] <= 1'b0;
        ign_cnt_r <= sat_inc(ign_cnt_r);
      end
    end
  end

  // Reserved bits seen set in an arriving word. Sticky, cleared by
  // writing one; a new sighting in the clear cycle is kept.
  always @* begin
    flags_nxt = flags_r;
    if (wr_go && hit(paddr, `DCW_OFF_FLAGS)) begin
      flags_nxt = flags_r & ~pwdata[1:0];
    end
    if (rx_take && rx_word[`DCW_BIT_RSVD2]) begin
      flags_nxt[`DCW_FLAG_RSVD2] = 1'b1;
    end
    if (rx_take && rx_word[`DCW_BIT_RSVD11]) begin
      flags_nxt[`DCW_FLAG_RSVD11] = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      flags_r <= 2'b00;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Level decode, one register stage after acceptance. Nothing here
  // remembers history, so the order of bit changes has no effect.
  // Reserved bits 2 and 11 feed no command.
  always @(posedge clk) begin
    if (rst) begin
      preset_sel_r <= 2'b00;
      coast_r <= 1'b1;
      quick_stop_r <= 1'b1;
      freq_hold_r <= 1'b1;
      start_en_r <= 1'b0;
      ramp_stop_r <= 1'b1;
      jog_r <= 1'b0;
      ramp2_sel_r <= 1'b0;
      bus_control_r <= 1'b0;
      user_bits_r <= 4'h0;
    end else begin
      preset_sel_r <= acc_word_r[`DCW_BIT_PRESET_HI:
                                 `DCW_BIT_PRESET_LO];
      coast_r <= ~acc_word_r[`DCW_BIT_COAST_N];
      quick_stop_r <= ~acc_word_r[`DCW_BIT_QSTOP_N];
      freq_hold_r <= ~acc_word_r[`DCW_BIT_HOLD_N];
      start_en_r <= acc_word_r[`DCW_BIT_START];
      ramp_stop_r <= ~acc_word_r[`DCW_BIT_START];
      jog_r <= acc_word_r[`DCW_BIT_JOG];
      ramp2_sel_r <= acc_word_r[`DCW_BIT_RAMP];
      bus_control_r <= acc_word_r[`DCW_BIT_VALID];
      // Only bits enabled in the map reach application control
      user_bits_r <= acc_word_r[`DCW_BIT_USER_HI:`DCW_BIT_USER_LO] &
                     ctrl_r[`DCW_CTRL_MAP_HI:`DCW_CTRL_MAP_LO];
    end
  end

  // Edge on the held acknowledge bit; an ignored word cannot make one
  dcw_edge_det u_ack_edge (
    .clk(clk),
    .rst(rst),
    .level(acc_word_r[`DCW_BIT_ACK]),
    .rise_r(ack_pulse)
  );

  dcw_fault_latch u_fault (
    .clk(clk),
    .rst(rst),
    .fault_set(fault_set),
    .fault_cond(fault_cond),
    .other_ack_ok(other_ack_ok),
    .ack_pulse(ack_pulse),
    .fault_r(fault_r),
    .ack_refused_r(ack_refused_r)
  );

endmodule // dcw_decoder

//--- dcw_decoder_properties.sv
// Timing checks for the command word decoder, bound to its ports.
// Assumes the fieldbus is the word source and the user map is all ones.
`timescale 1ns/1ps
module dcw_decoder_properties (
  // Clock and reset
  input wire clk,
  input wire rst,
  // APB handshake
  input wire psel,
  input wire penable,
  input wire pready,
  // Process data and faults
  input wire [15:0] pd_word,
  input wire pd_strobe,
  input wire fault_cond,
  // Decoded commands
  input wire [1:0] preset_sel_r,
  input wire coast_r,
  input wire quick_stop_r,
  input wire freq_hold_r,
  input wire start_en_r,
  input wire ramp_stop_r,
  input wire jog_r,
  input wire ramp2_sel_r,
  input wire bus_control_r,
  input wire [3:0] user_bits_r,
  input wire fault_r,
  input wire ack_refused_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_good; pd_strobe && pd_word[10]; endsequence
  sequence s_void; pd_strobe && !pd_word[10]; endsequence
  a_preset_pick: assert property (s_good |-> ##2
    preset_sel_r == $past(pd_word[1:0], 2)) else $error("preset");
  a_coast_now: assert property (s_good |-> ##2
    coast_r == !$past(pd_word[3], 2)) else $error("coast");
  a_quick_stop: assert property (s_good |-> ##2
    quick_stop_r == !$past(pd_word[4], 2)) else $error("qstop");
  a_hold_freq: assert property (s_good |-> ##2
    freq_hold_r == !$past(pd_word[5], 2)) else $error("hold");
  a_start_stop: assert property (s_good |-> ##2 start_en_r ==
    $past(pd_word[6], 2) && ramp_stop_r != start_en_r) else $error("start");
  a_jog_ramp: assert property (s_good |-> ##2 jog_r ==
    $past(pd_word[8], 2) && ramp2_sel_r == $past(pd_word[9], 2))
    else $error("jog or ramp");
  a_user_pass: assert property (s_good |-> ##2
    user_bits_r == $past(pd_word[15:12], 2)) else $error("user bits");
  a_void_keep: assert property (s_void |-> ##2 !bus_control_r &&
    $stable(preset_sel_r) && $stable(jog_r)) else $error("void word");
  a_fault_stays: assert property (fault_r && fault_cond |=>
    fault_r) else $error("fault cleared");
  a_refuse_pulse: assert property (ack_refused_r |-> fault_r ##1
    !ack_refused_r) else $error("refuse pulse");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no pready");
endmodule // dcw_decoder_properties

bind dcw_decoder dcw_decoder_properties u_props (.*);

//--- dcw_edge_det.v
// Rising-edge detector for the fault acknowledge bit.
// Assumes a level from logic on the same clock; emits a one-cycle pulse.
`timescale 1ns/1ps
module dcw_edge_det (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Level in, pulse out
  input wire level,
  output reg rise_r
);

  reg level_d_r;

  always @(posedge clk) begin
    if (rst) begin
      level_d_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      level_d_r <= level;
      // Steady high or steady low gives nothing
      rise_r <= level & ~level_d_r;
    end
  end

endmodule // dcw_edge_det

//--- dcw_fault_latch.v
// Latched drive fault with conditional acknowledge.
// Assumes fault inputs come from drive logic on the same clock.
`timescale 1ns/1ps
module dcw_fault_latch (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Fault sources
  input wire fault_set,
  input wire fault_cond,
  input wire other_ack_ok,
  // Acknowledge pulse
  input wire ack_pulse,
  // State
  output reg fault_r,
  output reg ack_refused_r
);

  wire clear_ok;

  assign clear_ok = ~fault_cond & other_ack_ok;

  always @(posedge clk) begin
    if (rst) begin
      fault_r <= 1'b0;
      ack_refused_r <= 1'b0;
    end else begin
      // A new fault in the ack cycle wins over the clear
      if (fault_set) begin
        fault_r <= 1'b1;
      end else if (ack_pulse && clear_ok) begin
        fault_r <= 1'b0;
      end
      ack_refused_r <= ack_pulse & fault_r & ~clear_ok;
    end
  end

endmodule // dcw_fault_latch

//--- dcw_fieldbus_ctrl.sv
// Model of the fieldbus controller that sends cyclic command words.
// Assumes the decoder samples pd_word whenever pd_strobe is high.
`timescale 1ns/1ps
module dcw_fieldbus_ctrl (
  // Clock
  input wire clk,
  // Cyclic process data
  output reg [15:0] pd_word,
  output reg pd_strobe
);
  initial begin
    pd_word = 16'h0000;
    pd_strobe = 1'b0;
  end
  // Idle cycles let the bench space words out; with none, words still go every other cycle
  task send(input [15:0] w, input integer idle);
    integer k;
    begin
      for (k = 0; k < idle; k = k + 1) @(posedge clk);
      @(posedge clk);
      pd_word <= {w[15:3], 1'b0, w[1:0]};
      pd_strobe <= 1'b1;
      @(posedge clk);
      pd_strobe <= 1'b0;
      // Stale word is inverted so no decoder can lean on it
      pd_word <= ~{w[15:3], 1'b0, w[1:0]};
    end
  endtask
endmodule // dcw_fieldbus_ctrl

//--- test_drive_command_word_decoder.sv
// Self-checking bench for the command word decoder.
// Assumes a fieldbus model drives words and an APB master reads counts.
`timescale 1ns/1ps
module test_drive_command_word_decoder;
  reg clk, rst, psel, penable, pwrite, fault_set, fault_cond, other_ack_ok;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg re, mv;
  reg [15:0] mw, w;
  wire [31:0] prdata;
  wire pready, pslverr, pd_strobe, coast_r, quick_stop_r, freq_hold_r;
  wire start_en_r, ramp_stop_r, jog_r, ramp2_sel_r, bus_control_r;
  wire fault_r, ack_refused_r;
  wire [15:0] pd_word;
  wire [1:0] preset_sel_r;
  wire [3:0] user_bits_r;
  integer err_total, tests_run, seed, acc, ign, i, n;
  dcw_decoder u_dut (.*);
  dcw_fieldbus_ctrl u_fb (.clk(clk), .pd_word(pd_word),
    .pd_strobe(pd_strobe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task cmp(input [8*8-1:0] nm, input [31:0] ex, input [31:0] ac);
    begin
      tests_run = tests_run + 1;
      if (ac !== ex) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s exp %h got %h", nm, ex, ac);
      end
    end
  endtask
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      // Look mid-cycle: pready seen high here is sampled at the next edge
      do begin
        @(negedge clk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      re = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
        err_total = err_total + 1;
        complete_run;
      end
    end
  endtask
  // Model keeps the last valid word; a void word only drops bus control
  task xmit(input [15:0] x, input integer idle);
    begin
      u_fb.send(x, idle);
      x[2] = 1'b0;
      mv = x[10];
      if (x[10]) mw = x;
      if (x[10]) acc = acc + 1;
      else ign = ign + 1;
      repeat (2) @(posedge clk);
      #1 cmp("outputs", {mw[1:0], ~mw[3], ~mw[4], ~mw[5], mw[6], ~mw[6],
        mw[8], mw[9], mv,
        mw[15:12]}, {preset_sel_r, coast_r, quick_stop_r, freq_hold_r,
        start_en_r, ramp_stop_r, jog_r, ramp2_sel_r, bus_control_r,
        user_bits_r});
    end
  endtask
  initial begin
    {err_total, tests_run, acc, ign, mw, mv} = 0;
    seed = 5;
    {psel, penable, pwrite, paddr, pwdata} = 0;
    rst = 1'b1;
    {fault_set, fault_cond, other_ack_ok} = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(0, 12'h004, 0);
    cmp("ctrl", 32'h000000F0, rd);
    apb(1, 12'h004, 32'h000000F0);
    apb(0, 12'hFFC, 0);
    cmp("slverr", 1, re);
    apb(0, 12'h000, 0);
    cmp("cmd rd", 0, rd);
    $display("register test done");
    for (i = 0; i < 40; i = i + 1) begin
      w = $random(seed);
      if (i % 4 != 3) w[10] = 1'b1;
      xmit(w, i % 3);
    end
    apb(0, 12'h00C, 0);
    cmp("acc cnt", acc, rd);
    apb(0, 12'h010, 0);
    cmp("ign cnt", ign, rd);
    $display("word test done");
    xmit(16'h0478, 0);
    @(posedge clk);
    fault_set <= 1'b1;
    fault_cond <= 1'b1;
    @(posedge clk);
    fault_set <= 1'b0;
    xmit(16'h04F8, 0);
    // Refusal pulse stands only in the cycle right after the latch edge
    cmp("refused", 2'b11, {ack_refused_r, fault_r});
    xmit(16'h04F8, 1);
    cmp("steady", 2'b01, {ack_refused_r, fault_r});
    fault_cond <= 1'b0;
    other_ack_ok <= 1'b1;
    xmit(16'h0478, 0);
    xmit(16'h04F8, 0);
    @(posedge clk);
    #1 cmp("cleared", 2'b00, {ack_refused_r, fault_r});
    $display("fault test done");
    complete_run;
  end
endmodule // test_drive_command_word_decoder
